// ===== core/oc_map.vh
// Purpose: register offsets, field positions and reset values of the compare channel
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   offsets are multiples of four
`ifndef OC_MAP_VH
`define OC_MAP_VH
`define ADDR_CONTROL        4'h0
`define ADDR_PAD_CONFIG     4'h4
`define ADDR_PRIMARY        4'h8
`define ADDR_SECONDARY      4'hC
`define CTRL_IDLE_STOP      13
`define CTRL_FAULT          4
`define CTRL_TIMER_SEL      3
`define CTRL_WRITE_MASK     16'h200F
`define PAD_TRISTATE        3
`define PAD_WRITE_MASK      16'h001E
`define MODE_OFF            3'h0
`define MODE_SET_HIGH       3'h1
`define MODE_SET_LOW        3'h2
`define MODE_TOGGLE         3'h3
`define MODE_SINGLE         3'h4
`define MODE_CONT           3'h5
`define MODE_PWM            3'h6
`define MODE_PWM_FAULT      3'h7
`define RESET_WORD          16'h0000
`endif

// ===== core/pin_sync.v
// Purpose: two flip-flop synchroniser for a pin level
// Assumes: single clock clk_i, synchronous reset
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module pin_sync
(
    input  wire clk_i,
    input  wire rst_i,
    input  wire async_i,
    output wire sync_o
);
    reg meta_reg;
    reg stable_reg;

    // two stages against metastability
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg   <= 1'b0;
            stable_reg <= 1'b0;
        end
        else
        begin
            meta_reg   <= async_i;
            stable_reg <= meta_reg;
        end
    end

    assign sync_o = stable_reg;
endmodule // pin_sync

// ===== core/output_compare_pwm_channel.v
// Purpose: one output compare / pwm channel with wishbone registers
// Assumes: timer counts arrive on clk_i; fault pin and idle level are asynchronous
// Notes:   registers: control 0x0, pad config 0x4, primary 0x8, secondary 0xC
//
// Summary of operation
// - mode 000 disables the channel
// - mode 001 starts low, match forces high
// - mode 010 starts high, match forces low
// - mode 011 toggles output on match
// - mode 100 emits exactly one pulse
// - mode 101 pulses every timer period
// - mode 110 pwm ignoring fault pin
// - mode 111 pwm watching fault pin
// - fault flag bit 4, hardware only
// - bit 3 picks time base b
// - idle stop bit halts in idle
// - tristate bit hides output from pin
// - duty resolution follows period width
// - unimplemented control bits read zero
// - secondary copied to duty on period match
// - duty zero low, above period high
// - duty equal period: one count low
// - single pulse sets flag, then stops
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "oc_map.vh"
module output_compare_pwm_channel
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output wire        ack_o,
    input  wire [15:0] time_base_a_count_i,
    input  wire [15:0] time_base_a_period_i,
    input  wire [15:0] time_base_b_count_i,
    input  wire [15:0] time_base_b_period_i,
    input  wire        cpu_idle_i,
    input  wire        fault_input_pin_i,
    output wire        compare_output_pin_o,
    output wire        compare_output_oe_o,
    output wire        compare_trigger_o,
    output wire        compare_interrupt_flag_o
);
    localparam [1:0] SP_ARMED = 2'b01;
    localparam [1:0] SP_DONE  = 2'b10;

    reg  [15:0] control_reg;
    reg  [15:0] pad_reg;
    reg  [15:0] primary_reg;
    reg  [15:0] secondary_reg;
    reg         out_reg;
    reg         out_next;
    reg         irq_reg;
    reg         irq_next;
    reg         fault_reg;
    reg  [1:0]  single_reg;
    reg  [1:0]  single_next;
    reg         ack_reg;
    reg         mode_write_reg;
    wire        fault_sync;
    wire        idle_sync;
    wire [2:0]  mode;
    wire [15:0] count;
    wire [15:0] period;
    wire        halted;
    wire        hit_primary;
    wire        hit_secondary;
    wire        hit_period;
    wire        is_pwm;
    wire        bus_req;
    wire        wr_ctrl;

    // asynchronous pins pass two flip-flops first
    pin_sync fault_sync_u
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (fault_input_pin_i),
        .sync_o  (fault_sync)
    );

    pin_sync idle_sync_u
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (cpu_idle_i),
        .sync_o  (idle_sync)
    );

    // byte-lane merge of a 16-bit register, masked to writable bits
    function [15:0] merge16;
        input [15:0] old_val;
        input [31:0] wdata;
        input [3:0]  lanes;
        input [15:0] wmask;
        reg   [15:0] tmp;
        begin
            tmp = old_val;
            if (lanes[0])
                tmp[7:0] = wdata[7:0];
            if (lanes[1])
                tmp[15:8] = wdata[15:8];
            merge16 = (tmp & wmask) | (old_val & ~wmask);
        end
    endfunction

    // field and time base selection
    assign mode   = control_reg[2:0];
    assign count  = control_reg[`CTRL_TIMER_SEL] ? time_base_b_count_i : time_base_a_count_i;
    assign period = control_reg[`CTRL_TIMER_SEL] ? time_base_b_period_i : time_base_a_period_i;
    assign halted = control_reg[`CTRL_IDLE_STOP] & idle_sync;
    assign is_pwm = (mode == `MODE_PWM) | (mode == `MODE_PWM_FAULT);

    // compare events; full 16-bit compare gives resolution set by period
    assign hit_primary   = (count == primary_reg);
    assign hit_secondary = (count == secondary_reg);
    assign hit_period    = (count == period);

    // wishbone classic slave, one wait state, ack drops after one cycle
    assign bus_req = cyc_i & stb_i;
    assign ack_o   = ack_reg;
    assign wr_ctrl = bus_req & ~ack_reg & we_i & (adr_i == `ADDR_CONTROL) & sel_i[0];

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_o   <= 32'h00000000;
        end
        else
        begin
            ack_reg <= bus_req & ~ack_reg;
            dat_o   <= 32'h00000000;
            if (bus_req & ~ack_reg & ~we_i)
            begin
                if (adr_i == `ADDR_CONTROL)
                    dat_o <= {16'h0000, control_reg[15:5], fault_reg, control_reg[3:0]};
                else if (adr_i == `ADDR_PAD_CONFIG)
                    dat_o <= {16'h0000, pad_reg};
                else if (adr_i == `ADDR_PRIMARY)
                    dat_o <= {16'h0000, primary_reg};
                else if (adr_i == `ADDR_SECONDARY)
                    dat_o <= {16'h0000, secondary_reg};
                else
                    dat_o <= 32'h00000000;
            end
        end
    end

    // register writes; primary is read-only while in pwm
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            control_reg    <= `RESET_WORD;
            pad_reg        <= `RESET_WORD;
            primary_reg    <= `RESET_WORD;
            secondary_reg  <= `RESET_WORD;
            mode_write_reg <= 1'b0;
        end
        else
        begin
            mode_write_reg <= wr_ctrl;
            if (bus_req & ~ack_reg & we_i)
            begin
                if (adr_i == `ADDR_CONTROL)
                    control_reg <= merge16(control_reg, dat_i, sel_i, `CTRL_WRITE_MASK);
                else if (adr_i == `ADDR_PAD_CONFIG)
                    pad_reg <= merge16(pad_reg, dat_i, sel_i, `PAD_WRITE_MASK);
                else if (adr_i == `ADDR_PRIMARY && !is_pwm)
                    primary_reg <= merge16(primary_reg, dat_i, sel_i, 16'hFFFF);
                else if (adr_i == `ADDR_SECONDARY)
                    secondary_reg <= merge16(secondary_reg, dat_i, sel_i, 16'hFFFF);
            end
            // duty double buffer loads at period end
            if (is_pwm && !halted && hit_period && !(bus_req & ~ack_reg & we_i & (adr_i == `ADDR_PRIMARY)))
                primary_reg <= secondary_reg;
        end
    end

    // waveform next-state logic
    always @*
    begin
        out_next    = out_reg;
        irq_next    = 1'b0;
        single_next = single_reg;
        case (mode)
            `MODE_OFF:
            begin
                out_next = 1'b0;
            end
            `MODE_SET_HIGH:
            begin
                if (hit_primary)
                begin
                    out_next = 1'b1;
                    irq_next = 1'b1;
                end
            end
            `MODE_SET_LOW:
            begin
                if (hit_primary)
                begin
                    out_next = 1'b0;
                    irq_next = 1'b1;
                end
            end
            `MODE_TOGGLE:
            begin
                if (hit_primary)
                begin
                    out_next = ~out_reg;
                    irq_next = 1'b1;
                end
            end
            `MODE_SINGLE:
            begin
                if (single_reg == SP_ARMED)
                begin
                    if (hit_secondary && out_reg)
                    begin
                        out_next    = 1'b0;
                        irq_next    = 1'b1;
                        single_next = SP_DONE;
                    end
                    else if (hit_primary)
                        out_next = 1'b1;
                end
                else
                    out_next = 1'b0;
            end
            `MODE_CONT:
            begin
                if (hit_secondary && out_reg)
                begin
                    out_next = 1'b0;
                    irq_next = 1'b1;
                end
                else if (hit_primary)
                    out_next = 1'b1;
            end
            default:
            begin
                // pwm: high below duty, so zero duty stays low, duty above period stays high
                if (fault_reg)
                    out_next = 1'b0;
                else if (primary_reg == 16'h0000)
                    out_next = 1'b0;
                else if (primary_reg > period)
                    out_next = 1'b1;
                else
                    out_next = (count < primary_reg);
                if (hit_period)
                    irq_next = 1'b1;
            end
        endcase
    end

    // output, flag, single-pulse state; a mode write reinitialises
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            out_reg    <= 1'b0;
            irq_reg    <= 1'b0;
            fault_reg  <= 1'b0;
            single_reg <= SP_ARMED;
        end
        else if (mode_write_reg)
        begin
            out_reg    <= (mode == `MODE_SET_LOW);
            irq_reg    <= 1'b0;
            // a fault seen in the same cycle as the rewrite wins over the clear
            fault_reg  <= (mode == `MODE_PWM_FAULT) & fault_sync;
            single_reg <= SP_ARMED;
        end
        else
        begin
            irq_reg <= 1'b0;
            // fault watched only in mode 111, held until mode rewrite
            if (mode == `MODE_PWM_FAULT && fault_sync)
                fault_reg <= 1'b1;
            else if (mode != `MODE_PWM_FAULT)
                fault_reg <= 1'b0;
            if (!halted)
            begin
                out_reg    <= out_next;
                irq_reg    <= irq_next;
                single_reg <= single_next;
            end
            if (mode == `MODE_PWM_FAULT && fault_sync)
                out_reg <= 1'b0;
        end
    end

    // pad: tristate hides the pin, trigger stays internal
    assign compare_trigger_o        = out_reg;
    assign compare_output_pin_o     = out_reg;
    assign compare_output_oe_o      = ~pad_reg[`PAD_TRISTATE] & (mode != `MODE_OFF);
    assign compare_interrupt_flag_o = irq_reg;
endmodule // output_compare_pwm_channel

// ===== dv/oc_asserts.sv
// Purpose: port-level properties of the compare channel
// Assumes: one clock, sync reset, control writes carry lane 0
// Notes:   mode and idle-stop bit are shadowed from bus writes
`timescale 1ns/1ps
module oc_asserts
(
    input wire        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, cpu_idle_i, fault_input_pin_i,
    input wire        compare_output_pin_o, compare_output_oe_o, compare_interrupt_flag_o,
    input wire [3:0]  adr_i, sel_i,
    input wire [31:0] dat_i
);
    reg [2:0] mode_reg;
    reg       stop_reg;
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // shadow moves only on the edge that takes a write, as the block does
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_reg <= 3'h0;
            stop_reg <= 1'b0;
        end
        else if (cyc_i && stb_i && we_i && !ack_o && adr_i == 4'h0 && sel_i[0])
        begin
            mode_reg <= dat_i[2:0];
            stop_reg <= dat_i[13];
        end
    end
    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    AST_ACK_ONCE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_RESET_QUIET: assert property ($fell(rst_i) |-> !ack_o && !compare_output_pin_o && !compare_interrupt_flag_o)
        else $error("outputs active after reset");
    AST_OFF_NO_OE: assert property (mode_reg == 3'h0 |-> !compare_output_oe_o)
        else $error("pin driven while off");
    AST_OFF_QUIET: assert property ((mode_reg == 3'h0)[*3] |-> !compare_output_pin_o && !compare_interrupt_flag_o)
        else $error("activity while off");
    AST_IRQ_ONCE: assert property (compare_interrupt_flag_o |=> !compare_interrupt_flag_o)
        else $error("flag longer than one cycle");
    AST_FAULT_LOW: assert property ((mode_reg == 3'h7 && fault_input_pin_i)[*4] |-> !compare_output_pin_o)
        else $error("output high during fault");
    AST_IDLE_HALT: assert property ((stop_reg && cpu_idle_i)[*5] |-> $stable(compare_output_pin_o))
        else $error("output moved while halted");
endmodule // oc_asserts

bind output_compare_pwm_channel oc_asserts u_asserts (.*);

// ===== dv/timer_model.sv
// Purpose: two free-running time bases and the fault source
// Assumes: both time bases step every clock
// Notes:   fault level follows the bench request one clock late
`timescale 1ns/1ps
module timer_model
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [15:0] per_a_i,
    input  wire [15:0] per_b_i,
    input  wire        fault_req_i,
    output reg  [15:0] cnt_a_o,
    output reg  [15:0] cnt_b_o,
    output reg         fault_o
);
    // wrap after the period value; a shrunk period never strands the count
    always @(posedge clk_i)
    begin
        cnt_a_o <= (rst_i || cnt_a_o >= per_a_i) ? 16'h0000 : cnt_a_o + 16'h0001;
        cnt_b_o <= (rst_i || cnt_b_o >= per_b_i) ? 16'h0000 : cnt_b_o + 16'h0001;
        fault_o <= fault_req_i && !rst_i;
    end
endmodule // timer_model

// ===== dv/testbench.sv
// Purpose: self-checking bench for the compare channel
// Assumes: timer model steps every clock; writes land at ack
// Notes:   compare and duty values drawn from a fixed seed
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, cpu_idle_i = 1'b0;
    logic        flt = 1'b0, v;
    logic [3:0]  adr_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic [15:0] per_a = 16'h000F, rd;
    wire  [15:0] cnt_a, cnt_b;
    wire  [31:0] dat_o;
    wire         ack_o, fault_input_pin_i, compare_output_pin_o, compare_output_oe_o, compare_trigger_o;
    wire         compare_interrupt_flag_o;
    integer      n_mismatch = 0, tests_run = 0, hi, irq, i, m, d;

    output_compare_pwm_channel u_dut (.sel_i(4'hF), .time_base_a_count_i(cnt_a), .time_base_a_period_i(per_a),
        .time_base_b_count_i(cnt_b), .time_base_b_period_i(16'h0013), .*);
    timer_model u_tm (.clk_i(clk_i), .rst_i(rst_i), .per_a_i(per_a), .per_b_i(16'h0013), .fault_req_i(flt),
        .cnt_a_o(cnt_a), .cnt_b_o(cnt_b), .fault_o(fault_input_pin_i));

    always #5 clk_i = ~clk_i;

    // level after a match: toggle inverts, else set-high gives 1
    function automatic logic lvl(input integer md, input logic pv);
        lvl = (md == 3) ? ~pv : (md == 1);
    endfunction
    // high counts over two periods of 128 counts
    function automatic integer pwm_hi(input integer dt);
        pwm_hi = (dt > 127) ? 256 : 2 * dt;
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask
    task end_sim;
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one classic cycle, held until ack is sampled, then a dead cycle
    task wb(input logic w, input logic [3:0] a, input logic [15:0] dv);
        integer k;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {16'h0000, dv};
        for (k = 0; k < 20 && ack_o !== 1'b1; k++)
            @(posedge clk_i);
        rd = dat_o[15:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
        if (k == 20)
        begin
            n_mismatch++;
            end_sim;
        end
    endtask
    task rw(input logic [3:0] a, input logic [15:0] dv, input logic [15:0] e);
        wb(1'b1, a, dv);
        wb(1'b0, a, 16'h0000);
        chk(rd, e);
    endtask
    task wirq(input integer n);
        for (i = 0; i < n && compare_interrupt_flag_o !== 1'b1; i++)
            @(posedge clk_i);
    endtask
    task meas(input integer n);
        hi = 0;
        irq = 0;
        repeat (n)
        begin
            @(posedge clk_i);
            hi += compare_output_pin_o;
            irq += compare_interrupt_flag_o;
        end
    endtask

    initial
    begin
        d = $urandom(32'hD9858399);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        // reset value, writable bits, read-only flag, unmapped place
        wb(1'b0, 4'h0, 16'h0000);
        chk(rd, 16'h0000);
        rw(4'h0, 16'hFFFF, 16'h200F);
        rw(4'h4, 16'hFFFF, 16'h001E);
        chk(compare_output_oe_o, 1'b0);
        rw(4'h2, 16'hFFFF, 16'h0000);
        wb(1'b1, 4'h4, 16'h0000);
        wb(1'b1, 4'h0, 16'h0000);
        meas(40);
        chk(hi + irq, 0);
        // single-compare modes on time base b, random compare value
        for (m = 1; m < 4; m++)
        begin
            wb(1'b1, 4'h8, 16'($urandom % 16));
            wb(1'b1, 4'h0, 16'(m + 8));
            wirq(60);
            chk(i < 60, 1);
            v = compare_output_pin_o;
            @(posedge clk_i);
            wirq(60);
            chk(i < 60, 1);
            chk(compare_output_pin_o, lvl(m, v));
        end
        // compare 18 lies beyond time base a but within time base b
        wb(1'b1, 4'h8, 16'h0012);
        wb(1'b1, 4'h0, 16'h0001);
        wirq(60);
        chk(i, 60);
        wb(1'b1, 4'h0, 16'h0009);
        wirq(60);
        chk(i < 60, 1);
        // pulses from 3 to 9 on time base a, then idle halting
        wb(1'b1, 4'h8, 16'h0003);
        wb(1'b1, 4'hC, 16'h0009);
        wb(1'b1, 4'h0, 16'h0004);
        meas(48);
        chk(hi, 32'd6);
        chk(irq, 32'd1);
        for (m = 0; m < 3; m++)
        begin
            wb(1'b1, 4'h0, m == 1 ? 16'h2005 : 16'h0005);
            cpu_idle_i <= (m != 0);
            wirq(40);
            meas(48);
            chk(irq, m == 1 ? 0 : 3);
        end
        cpu_idle_i <= 1'b0;
        // pwm on a 7-bit period, fault pin toggled while ignored
        per_a <= 16'h007F;
        wb(1'b1, 4'h0, 16'h0006);
        for (m = 0; m < 4; m++)
        begin
            d = (m == 0) ? 0 : (m == 1) ? 127 : (m == 2) ? 128 : 1 + $urandom % 126;
            flt <= m[0];
            wb(1'b1, 4'hC, 16'(d));
            meas(129);
            meas(256);
            chk(hi, pwm_hi(d));
        end
        // fault holds the output low until the mode is rewritten
        flt <= 1'b0;
        wb(1'b1, 4'hC, 16'h00C8);
        wb(1'b1, 4'h0, 16'h0007);
        meas(130);
        flt <= 1'b1;
        meas(8);
        meas(130);
        chk(hi, 0);
        wb(1'b0, 4'h0, 16'h0000);
        chk(rd, 16'h0017);
        flt <= 1'b0;
        meas(130);
        chk(hi, 0);
        rw(4'h0, 16'h0007, 16'h0007);
        meas(130);
        meas(20);
        chk(hi, 20);
        chk(compare_output_oe_o, 1'b1);
        wb(1'b1, 4'h4, 16'h0008);
        chk({compare_output_oe_o, compare_trigger_o}, 2'b01);
        end_sim;
    end
endmodule // testbench
